/* hw/scui_cfg.svh */
`ifndef SCUI_CFG_SVH
`define SCUI_CFG_SVH
// ==========================================
// addresses and bank select
`define SCUI_ADDR_EVENT      8'hae
`define SCUI_BANK_ID         1'b0
`define SCUI_BANK_EN         1'b1
// ==========================================
// flag positions, shared by both registers
`define SCUI_BIT_TBE         7
`define SCUI_BIT_RSVD        6
`define SCUI_BIT_OVC         5
`define SCUI_BIT_VERR        4
`define SCUI_BIT_WTO         3
`define SCUI_BIT_SENT        2
`define SCUI_BIT_RCVD        1
`define SCUI_BIT_PAR         0
`define SCUI_NUM_SRC         8
// ==========================================
// reset values and masks
`define SCUI_RESET_VAL       8'h00
`define SCUI_IMPL_MASK       8'hbf
// source index shown when nothing is pending
`define SCUI_SRC_NONE        3'h0
`endif

/* hw/scui_irq_flags.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scui_cfg.svh"
// Function
// - set buffer empty flag, bit 7
// - any event id read clears flags
// - set overcurrent flag, bit 5
// - set supply out of range flag, bit 4
// - set wait timeout flag, bit 3
// - set char sent flag, bit 2
// - set char received flag, bit 1
// - parity flag with sent or received
// - flag interrupts only when enabled
// - fixed priority order for simultaneous events
// - id register read only, bank 0
// - enable bit one enables source
// - flags and enables reset to zero
// - bank select picks register set
module scui_irq_flags
(
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    // special function register bus
    input  wire logic [7:0]          sfr_addr,
    input  wire logic                sfr_rd,
    input  wire logic                sfr_wr,
    input  wire logic [7:0]          sfr_wdata,
    output var  logic [7:0]          sfr_rdata,
    // bank select from the card selection register
    input  wire logic                register_bank_select,
    // event strobes from the card uart datapath
    input  wire logic                tx_holding_moved,
    input  wire logic                char_sent_done,
    input  wire logic                char_received_done,
    input  wire logic                rx_parity_bad,
    input  wire logic                wait_counter_expired,
    // analog comparator levels from the card supply
    input  wire logic                card_overcurrent_pin,
    input  wire logic                card_supply_out_pin,
    // interrupt request and top pending source
    output logic                     irq_req,
    output logic                     irq_any_pending,
    output var  logic [2:0]          irq_top_src
);
    // flag and enable registers
    scui_pkg::scui_byte_t flags_reg;
    scui_pkg::scui_byte_t flags_next;
    scui_pkg::scui_byte_t enable_reg;
    scui_pkg::scui_byte_t enable_next;
    // synchronised supply comparators and their delayed copies
    logic                 ovc_sync;
    logic                 verr_sync;
    logic                 ovc_d_reg;
    logic                 verr_d_reg;
    // decoded accesses
    wire                  addr_hit;
    wire                  id_read;
    wire                  en_write;
    wire                  en_read;
    // new events this cycle and gated requests
    scui_pkg::scui_byte_t set_vec;
    wire [7:0]            pend_vec;
    scui_pkg::scui_src_t  top_src;

    // ==========================================
    // pin synchronisers
    scui_sync u_sync_ovc
    (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (card_overcurrent_pin),
        .sync_out (ovc_sync)
    );

    scui_sync u_sync_verr
    (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (card_supply_out_pin),
        .sync_out (verr_sync)
    );

    // ==========================================
    // priority encoder, highest index first
    function automatic scui_pkg::scui_src_t top_of
    (
        input logic [7:0] vec
    );
        scui_pkg::scui_src_t res;
        res = `SCUI_SRC_NONE;
        for (int i = 0; i < `SCUI_NUM_SRC; i++)
        begin
            if (vec[i])
            begin
                res = i[2:0];
            end
        end
        return res;
    endfunction : top_of

    // ==========================================
    // address decode
    // bank select steers access
    assign addr_hit = (sfr_addr == `SCUI_ADDR_EVENT);
    assign id_read  = addr_hit & sfr_rd
                    & (register_bank_select == `SCUI_BANK_ID);
    assign en_write = addr_hit & sfr_wr
                    & (register_bank_select == `SCUI_BANK_EN);
    assign en_read  = addr_hit & sfr_rd
                    & (register_bank_select == `SCUI_BANK_EN);

    // ==========================================
    // event set vector
    always_comb
    begin
        set_vec = `SCUI_RESET_VAL;
        set_vec[`SCUI_BIT_TBE]  = tx_holding_moved;
        set_vec[`SCUI_BIT_OVC]  = ovc_sync & ~ovc_d_reg;
        set_vec[`SCUI_BIT_VERR] = verr_sync & ~verr_d_reg;
        set_vec[`SCUI_BIT_WTO]  = wait_counter_expired;
        set_vec[`SCUI_BIT_SENT] = char_sent_done;
        set_vec[`SCUI_BIT_RCVD] = char_received_done;
        set_vec[`SCUI_BIT_PAR]  = rx_parity_bad
                                & (char_sent_done | char_received_done);
    end

    // ==========================================
    // next flag value
    // read clears, a same-cycle set wins
    assign flags_next  = ((id_read ? `SCUI_RESET_VAL : flags_reg) | set_vec)
                       & `SCUI_IMPL_MASK;
    assign enable_next = en_write ? (sfr_wdata & `SCUI_IMPL_MASK)
                                  : enable_reg;

    // ==========================================
    // registers
    // all zero after reset
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            flags_reg  <= `SCUI_RESET_VAL;
            enable_reg <= `SCUI_RESET_VAL;
            ovc_d_reg  <= 1'b0;
            verr_d_reg <= 1'b0;
        end
        else
        begin
            flags_reg  <= flags_next;
            enable_reg <= enable_next;
            ovc_d_reg  <= ovc_sync;
            verr_d_reg <= verr_sync;
        end
    end

    // ==========================================
    // read data, registered, zero when unselected
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            sfr_rdata <= `SCUI_RESET_VAL;
        end
        else if (id_read)
        begin
            sfr_rdata <= flags_reg;
        end
        else if (en_read)
        begin
            sfr_rdata <= enable_reg;
        end
        else
        begin
            sfr_rdata <= `SCUI_RESET_VAL;
        end
    end

    // ==========================================
    // interrupt request
    // flag gated by its enable
    assign pend_vec        = flags_reg & enable_reg;
    assign irq_req         = |pend_vec;
    assign irq_any_pending = |flags_reg;
    assign top_src         = top_of(pend_vec);

    // top source held in a flop
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            irq_top_src <= `SCUI_SRC_NONE;
        end
        else
        begin
            irq_top_src <= top_src;
        end
    end

    // ==========================================
    // checks
    // read clears unless new event
    a_read_clears: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        id_read |=> (flags_reg == $past(set_vec & `SCUI_IMPL_MASK)))
        else $error("flags not cleared by id read");

    a_tbe_sets: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        tx_holding_moved |=> flags_reg[`SCUI_BIT_TBE])
        else $error("buffer empty flag missing");

    a_wto_sets: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        wait_counter_expired |=> flags_reg[`SCUI_BIT_WTO])
        else $error("timeout flag missing");

    a_sent_sets: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        char_sent_done |=> flags_reg[`SCUI_BIT_SENT])
        else $error("sent flag missing");

    a_rcvd_sets: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        char_received_done |=> flags_reg[`SCUI_BIT_RCVD])
        else $error("received flag missing");

    // parity pairs with a char flag
    a_par_pairs: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(flags_reg[`SCUI_BIT_PAR]) |->
        (flags_reg[`SCUI_BIT_SENT] | flags_reg[`SCUI_BIT_RCVD]))
        else $error("parity flag set alone");

    a_rcvd_parity: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (char_received_done & rx_parity_bad) |=> flags_reg[`SCUI_BIT_PAR])
        else $error("parity flag missing");

    // overcurrent pin sets bit 5 in three cycles
    a_ovc_sets: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(card_overcurrent_pin) ##1 card_overcurrent_pin[*2]
        |=> flags_reg[`SCUI_BIT_OVC])
        else $error("overcurrent flag missing");

    // supply pin sets bit 4 in three cycles
    a_verr_sets: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(card_supply_out_pin) ##1 card_supply_out_pin[*2]
        |=> flags_reg[`SCUI_BIT_VERR])
        else $error("supply flag missing");

    // request held while an enabled flag stays
    a_irq_held: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        ((|pend_vec) & ~id_read & ~en_write) |=> irq_req)
        else $error("request dropped while pending");

    a_masked_quiet: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (enable_reg == `SCUI_RESET_VAL) |-> !irq_req)
        else $error("request with all sources disabled");

    // enabled buffer empty is top source
    a_top_tbe: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (flags_reg[`SCUI_BIT_TBE] & enable_reg[`SCUI_BIT_TBE])
        |=> (irq_top_src == `SCUI_BIT_TBE))
        else $error("buffer empty not on top");

    // write in bank 0 leaves enables alone
    a_id_ro: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (addr_hit & sfr_wr & ~register_bank_select) |=> $stable(enable_reg))
        else $error("write to id bank changed enables");

    a_en_write: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        en_write |=> enable_reg == ($past(sfr_wdata) & `SCUI_IMPL_MASK))
        else $error("enable write lost");

    // no selected read, read data zero
    a_rdata_idle: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !(id_read | en_read) |=> (sfr_rdata == `SCUI_RESET_VAL))
        else $error("read data not zero when idle");

    a_reset_zero: assert property (
        @(posedge sys_clk)
        !reset_n |=> ((flags_reg == `SCUI_RESET_VAL)
                      && (enable_reg == `SCUI_RESET_VAL)))
        else $error("registers not zero after reset");
endmodule : scui_irq_flags
`default_nettype wire

/* hw/scui_pkg.sv */
// ==========================================
// shared types
package scui_pkg;
    // one byte of flags or enables
    typedef logic [7:0] scui_byte_t;
    // source index out of the priority encoder
    typedef logic [2:0] scui_src_t;
endpackage : scui_pkg

/* hw/scui_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// two-stage synchroniser for event pins
module scui_sync
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // async in, synced out
    input  wire logic async_in,
    output var  logic sync_out
);
    // first stage, read only by the second
    logic meta_reg;

    // ==========================================
    // two flops in series
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : scui_sync
`default_nettype wire

/* verification/scui_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// processor core model on the sfr bus
module scui_cpu_model
(
    // clock
    input  wire logic       sys_clk,
    // sfr bus towards the block
    output var  logic [7:0] sfr_addr,
    output var  logic       sfr_rd,
    output var  logic       sfr_wr,
    output var  logic [7:0] sfr_wdata,
    output var  logic       register_bank_select,
    input  wire logic [7:0] sfr_rdata
);
    // idle bus from time zero
    initial
    begin
        sfr_addr = 8'h00;
        sfr_rd = 1'b0;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        register_bank_select = 1'b0;
    end
    // bank before access
    // one write, strobe held for one edge
    task automatic sfr_write(input logic bank, input logic [7:0] addr,
                             input logic [7:0] data);
        @(negedge sys_clk);
        register_bank_select = bank;
        sfr_addr = addr;
        sfr_wdata = data;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
        sfr_wdata = ~data;
    endtask : sfr_write
    // caller keeps the copy
    // one read, data taken the cycle after
    task automatic sfr_read(input logic bank, input logic [7:0] addr,
                            output logic [7:0] data);
        @(negedge sys_clk);
        register_bank_select = bank;
        sfr_addr = addr;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        data = sfr_rdata;
    endtask : sfr_read
endmodule : scui_cpu_model
`default_nettype wire

/* verification/scui_irq_flags_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); err_total++; end end
// ==========================================
// self-checking bench
module scui_irq_flags_bench;
    logic       sys_clk, reset_n, sfr_rd, sfr_wr, bank;  // clock, bus
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;       // bus data
    logic       tx_mv, sent, rcvd, par, wto, ovc, sup;   // event inputs
    logic       irq_req, irq_any_pending;                // requests
    logic [2:0] irq_top_src;                             // top source
    int         err_total = 0, cmp_count = 0, cycles = 0;
    logic [7:0] exp_tab [5] = '{8'h80, 8'h08, 8'h04, 8'h02, 8'h00};
    scui_irq_flags scui_irq_flags_inst (.sys_clk(sys_clk),
        .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .register_bank_select(bank), .tx_holding_moved(tx_mv),
        .char_sent_done(sent), .char_received_done(rcvd),
        .rx_parity_bad(par), .wait_counter_expired(wto),
        .card_overcurrent_pin(ovc), .card_supply_out_pin(sup),
        .irq_req(irq_req), .irq_any_pending(irq_any_pending),
        .irq_top_src(irq_top_src));
    scui_cpu_model scui_cpu_model_inst (.sys_clk(sys_clk),
        .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .register_bank_select(bank),
        .sfr_rdata(sfr_rdata));
    // 250 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            print_verdict();
        end
    end
    // counts, verdict, end of run
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // one-cycle strobe pulse: tx, wait, sent, rcvd, parity
    task automatic fire(input logic [4:0] s);
        @(negedge sys_clk);
        {tx_mv, wto, sent, rcvd, par} = s;
        @(negedge sys_clk);
        {tx_mv, wto, sent, rcvd, par} = 5'h00;
    endtask : fire
    // reset values of both registers
    task automatic test_reset();
        scui_cpu_model_inst.sfr_read(1'b0, 8'hae, v);
        `CHK(v, 8'h00)
        scui_cpu_model_inst.sfr_read(1'b1, 8'hae, v);
        `CHK(v, 8'h00)
        $display("test reset done");
    endtask : test_reset
    // enable access, read-only id, unmapped place
    task automatic test_regs();
        scui_cpu_model_inst.sfr_write(1'b1, 8'hae, 8'hff);
        scui_cpu_model_inst.sfr_read(1'b1, 8'hae, v);
        `CHK(v, 8'hbf)
        scui_cpu_model_inst.sfr_write(1'b0, 8'hae, 8'hff);
        scui_cpu_model_inst.sfr_read(1'b0, 8'hae, v);
        `CHK(v, 8'h00)
        scui_cpu_model_inst.sfr_read(1'b0, 8'h55, v);
        `CHK(v, 8'h00)
        $display("test regs done");
    endtask : test_regs
    // tx, wait, sent, rcvd strobes alone, request, read clears
    task automatic test_events();
        for (int i = 0; i < 4; i++)
        begin
            fire(5'h10 >> i);
            `CHK(irq_req, 1'b1)
            scui_cpu_model_inst.sfr_read(1'b0, 8'hae, v);
            `CHK(v, exp_tab[i])
            `CHK(irq_req, 1'b0)
        end
        ovc = 1'b1;
        repeat (5) @(negedge sys_clk);
        scui_cpu_model_inst.sfr_read(1'b0, 8'hae, v);
        `CHK(v, 8'h20)
        sup = 1'b1;
        repeat (5) @(negedge sys_clk);
        scui_cpu_model_inst.sfr_read(1'b0, 8'hae, v);
        `CHK(v, 8'h10)
        fire(5'h03);
        scui_cpu_model_inst.sfr_read(1'b0, 8'hae, v);
        `CHK(v, 8'h03)
        $display("test events done");
    endtask : test_events
    // masked flag still sets but does not request
    task automatic test_mask();
        scui_cpu_model_inst.sfr_write(1'b1, 8'hae, 8'h00);
        fire(5'h08);
        `CHK(irq_req, 1'b0)
        `CHK(irq_any_pending, 1'b1)
        scui_cpu_model_inst.sfr_write(1'b1, 8'hae, 8'h08);
        `CHK(irq_req, 1'b1)
        scui_cpu_model_inst.sfr_read(1'b0, 8'hae, v);
        `CHK(v, 8'h08)
        $display("test mask done");
    endtask : test_mask
    // simultaneous events, highest enabled wins
    task automatic test_priority();
        scui_cpu_model_inst.sfr_write(1'b1, 8'hae, 8'hff);
        fire(5'h1f);
        repeat (2) @(negedge sys_clk);
        `CHK(irq_top_src, 3'h7)
        scui_cpu_model_inst.sfr_write(1'b1, 8'hae, 8'h07);
        repeat (2) @(negedge sys_clk);
        `CHK(irq_top_src, 3'h2)
        scui_cpu_model_inst.sfr_read(1'b0, 8'hae, v);
        `CHK(v, 8'h8f)
        $display("test priority done");
    endtask : test_priority
    // main sequence
    initial
    begin
        reset_n = 1'b0;
        {tx_mv, wto, sent, rcvd, par, ovc, sup} = 7'h00;
        repeat (16) @(negedge sys_clk);
        reset_n = 1'b1;
        test_reset();
        test_regs();
        test_events();
        test_mask();
        test_priority();
        print_verdict();
    end
endmodule : scui_irq_flags_bench
`default_nettype wire
